// [hdl/lrs_regs.vh]
// Purpose: register map and constants of the local/remote setpoint selector
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes: setpoints and rates are signed hundredths of a percent
`ifndef LRS_REGS_VH
`define LRS_REGS_VH
// ==========================================================================
// register offsets
`define LRS_ADDR_W 6
`define LRS_OFF_CTRL 6'h00
`define LRS_OFF_LINKS 6'h04
`define LRS_OFF_SLEW 6'h08
`define LRS_OFF_SPEED 6'h0C
`define LRS_OFF_LOW 6'h10
`define LRS_OFF_UPP 6'h14
`define LRS_OFF_STATUS 6'h18
`define LRS_OFF_OUTPUT 6'h1C
`define LRS_OFF_REGVAL 6'h20
// ==========================================================================
// field positions
`define LRS_CTRL_LOCK 1:0
`define LRS_CTRL_RESTART 3:2
`define LRS_LINK_REMOTE 7:0
`define LRS_LINK_LOCAL 15:8
`define LRS_LINK_FORCE 23:16
// ==========================================================================
// setting encodings
`define LRS_LOCK_NONE 2'h0
`define LRS_LOCK_REMOTE 2'h1
`define LRS_LOCK_LOCAL 2'h2
`define LRS_START_LAST 2'h0
`define LRS_START_LOCAL 2'h1
`define LRS_START_REMOTE 2'h2
// ==========================================================================
// reset values and ranges (hundredths of a percent)
`define LRS_RST_LOCK 2'h2
`define LRS_RST_RESTART 2'h0
`define LRS_RST_LINK 8'h00
`define LRS_RST_SLEW 16'sh4E20
`define LRS_RST_SPEED 16'sh03E8
`define LRS_RST_LOW 16'sh0000
`define LRS_RST_UPP 16'sh2710
`define LRS_SLEW_MIN 16'sh0064
`define LRS_RATE_MAX 16'sh4E20
`define LRS_LIM_MIN 16'shD828
`define LRS_LIM_MAX 16'sh27D8
`define LRS_LINK_LO_MAX 8'hAA
`define LRS_LINK_HI_MIN 8'hE1
`define LRS_LINK_HI_MAX 8'hF0
`define LRS_ADJ_OUT_MIN 8'hE1
`define LRS_ADJ_OUT_MAX 8'hE4
// ==========================================================================
// timing
`define LRS_CLK_HZ 20000000
`define LRS_SCAN_MS 100
`define LRS_MS_PER_S 1000
`define LRS_BLINK_SCANS 8'h05
`define LRS_RESP_OKAY 2'h0
`define LRS_RESP_SLVERR 2'h2
`endif

// [hdl/lrs_selector.v]
// Purpose: local/remote setpoint selector with key-driven local register
// Assumes: setpoint inputs come from logic on clock_in, keys and the
//   force-local level come from pins
// Notes: all setpoint arithmetic is done once per scan tick
//
// Behaviour
// [RULE_01] A mode key press toggles the switch unless it is locked.
// [RULE_02] Force-local high forces local mode.
// [RULE_03] A connected local input replaces the internal register.
// [RULE_04] Remote input is output only for switch remote, no force.
// [RULE_05] LED off in remote, flashing when forced, lit when local.
// [RULE_06] The lock holds the switch free, remote or local (default).
// [RULE_07] At restart the mode is last, local or remote by setting.
// [RULE_08] In remote the output slews at most at the set rate.
// [RULE_09] In remote the internal register follows the remote input.
// [RULE_10] Keys ramp the register at the set speed while shown.
// [RULE_11] The register is clamped between the two limits.
// [RULE_12] Two discrete outputs show remote and local mode.
// [RULE_13] Shown adjustable outputs let keys reach the adjuster.
// [RULE_14] Links hold 0 to 170 or 225 to 240, 0 unconnected.
// [RULE_15] The remote setpoint is never amplitude limited.
// [RULE_16] Setpoints are fixed-point percent, rates scaled per tick.
// [RULE_17] LED flashing toggles from a shared blink tick.
`timescale 1ns/1ps
`include "lrs_regs.vh"
module lrs_selector
#(
  parameter SCAN_CYCLES = `LRS_CLK_HZ / `LRS_MS_PER_S * `LRS_SCAN_MS,
  parameter SP_W = 16
)
(
  input wire clock_in,
  input wire nrst_in,
  input wire [`LRS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [`LRS_ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire signed [SP_W-1:0] remote_sp_in,
  input wire signed [SP_W-1:0] local_sp_in,
  input wire force_local_in,
  input wire key_mode_in,
  input wire key_up_in,
  input wire key_down_in,
  input wire [7:0] display_addr_in,
  input wire retained_local_in,
  output reg signed [SP_W-1:0] setpoint_out,
  output reg remote_mode_out,
  output reg local_mode_out,
  output reg local_led_out,
  output reg fwd_key_up_out,
  output reg fwd_key_down_out
);

  // ========================================================================
  // settings
  reg [1:0] mode_lock_setting;
  reg [1:0] restart_mode_setting;
  reg [7:0] remote_source_link;
  reg [7:0] local_source_link;
  reg [7:0] force_local_link;
  reg signed [SP_W-1:0] remote_slew_rate;
  reg signed [SP_W-1:0] key_ramp_speed;
  reg signed [SP_W-1:0] register_lower_limit;
  reg signed [SP_W-1:0] register_upper_limit;
  reg signed [SP_W-1:0] local_reg;
  reg mode_switch;
  reg started;
  reg [31:0] scan_cnt;
  reg scan_tick;
  reg [7:0] blink_cnt;
  reg blink;
  reg mode_prev;

  // ========================================================================
  // helpers
  // a link address is legal in the low band or the high band 225 to 240
  function link_ok;
    input [7:0] a;
    begin
      link_ok = (a <= `LRS_LINK_LO_MAX) ||
        (a >= `LRS_LINK_HI_MIN && a <= `LRS_LINK_HI_MAX);
    end
  endfunction

  // an adjuster output can be driven by the keys
  function is_adj;
    input [7:0] a;
    begin
      is_adj = (a >= `LRS_ADJ_OUT_MIN && a <= `LRS_ADJ_OUT_MAX);
    end
  endfunction

  function signed [SP_W-1:0] clamp;
    input signed [SP_W:0] v;
    input signed [SP_W-1:0] lo;
    input signed [SP_W-1:0] hi;
    begin
      if (v < lo)
        clamp = lo;
      else if (v > hi)
        clamp = hi;
      else
        clamp = v[SP_W-1:0];
    end
  endfunction

  // per-tick step from a rate in hundredths of a percent per second
  function signed [SP_W-1:0] per_tick;
    input signed [SP_W-1:0] rate;
    reg [31:0] p;
    begin
      p = {{(32-SP_W){1'b0}}, rate} * `LRS_SCAN_MS / `LRS_MS_PER_S;
      per_tick = p[SP_W-1:0];
    end
  endfunction

  // ========================================================================
  // pin synchronisers: a level changes once stages two and three agree
  wire [3:0] pins = {key_down_in, key_up_in, key_mode_in, force_local_in};
  wire [3:0] pin_lvl;
  wire force_lvl = pin_lvl[0];
  wire mode_lvl = pin_lvl[1];
  wire up_lvl = pin_lvl[2];
  wire down_lvl = pin_lvl[3];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_sync
      reg [2:0] sync;
      reg lvl;
      assign pin_lvl[g] = lvl;
      always @(posedge clock_in)
      begin
        if (!nrst_in)
        begin
          sync <= 3'h0;
          lvl <= 1'b0;
        end
        else
        begin
          sync <= {sync[1:0], pins[g]};
          if (sync[1] == sync[2])
            lvl <= sync[2];
        end
      end
    end
  endgenerate

  // ========================================================================
  // scan tick and blink tick
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      scan_cnt <= 32'h0;
      scan_tick <= 1'b0;
      blink_cnt <= 8'h0;
      blink <= 1'b0;
    end
    else
    begin
      scan_tick <= (scan_cnt == SCAN_CYCLES - 1); // [RULE_16]
      scan_cnt <= (scan_cnt == SCAN_CYCLES - 1) ? 32'h0 : scan_cnt + 32'h1;
      if (scan_tick)
      begin
        // shared blink rate, independent of the setpoint arithmetic
        if (blink_cnt == `LRS_BLINK_SCANS - 8'h1)
        begin
          blink_cnt <= 8'h0;
          blink <= ~blink; // [RULE_17]
        end
        else
          blink_cnt <= blink_cnt + 8'h1;
      end
    end
  end

  // ========================================================================
  // mode decode
  wire force_eff = (force_local_link != 8'h0) && force_lvl; // [RULE_02]
  wire local_eff = mode_switch || force_eff; // [RULE_04]
  wire local_conn = (local_source_link != 8'h0); // [RULE_03]
  wire sp_shown = is_adj(display_addr_in); // [RULE_13]
  wire own_keys = sp_shown && local_eff && !local_conn; // [RULE_10]
  wire signed [SP_W-1:0] local_src = local_conn ? local_sp_in : local_reg;
  wire signed [SP_W-1:0] slew_step = per_tick(remote_slew_rate);
  wire signed [SP_W-1:0] ramp_step = per_tick(key_ramp_speed);
  // both keys or neither leave the register where it is
  wire signed [SP_W:0] ramp_ext = {ramp_step[SP_W-1], ramp_step};
  wire signed [SP_W:0] ramp_delta = (!own_keys || up_lvl == down_lvl) ?
    {(SP_W+1){1'b0}} : (up_lvl ? ramp_ext : -ramp_ext);
  wire adj_sel = sp_shown && (local_eff ? is_adj(local_source_link) :
    is_adj(remote_source_link));

  // mode switch: power-up choice, then key toggles under the lock
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      mode_switch <= 1'b0;
      started <= 1'b0;
      mode_prev <= 1'b0;
    end
    else
    begin
      mode_prev <= mode_lvl;
      started <= 1'b1;
      if (!started)
      begin
        // retained level is read only after release, never under reset
        case (restart_mode_setting)
          `LRS_START_LOCAL: mode_switch <= 1'b1; // [RULE_07]
          `LRS_START_REMOTE: mode_switch <= 1'b0; // [RULE_07]
          default: mode_switch <= retained_local_in; // [RULE_07]
        endcase
      end
      else if (mode_lock_setting == `LRS_LOCK_REMOTE)
        mode_switch <= 1'b0; // [RULE_06]
      else if (mode_lock_setting == `LRS_LOCK_LOCAL)
        mode_switch <= 1'b1; // [RULE_06]
      else if (mode_lvl && !mode_prev)
        mode_switch <= ~mode_switch; // [RULE_01]
    end
  end

  // ========================================================================
  // output slew, local register tracking and key ramp
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      setpoint_out <= {SP_W{1'b0}};
      local_reg <= `LRS_RST_LOW;
    end
    else if (scan_tick)
    begin
      if (!local_eff)
      begin
        // remote value passes unlimited, only its rate is bounded
        if (remote_sp_in > setpoint_out + slew_step)
          setpoint_out <= setpoint_out + slew_step; // [RULE_08]
        else if (remote_sp_in < setpoint_out - slew_step)
          setpoint_out <= setpoint_out - slew_step; // [RULE_08]
        else
          setpoint_out <= remote_sp_in; // [RULE_15]
        local_reg <= clamp({remote_sp_in[SP_W-1], remote_sp_in},
          register_lower_limit, register_upper_limit); // [RULE_09] [RULE_11]
      end
      else
      begin
        setpoint_out <= local_src; // [RULE_03] [RULE_04]
        local_reg <= clamp({local_reg[SP_W-1], local_reg} + ramp_delta,
          register_lower_limit, register_upper_limit); // [RULE_10] [RULE_11]
      end
    end
  end

  // discrete outputs, LED and key forwarding
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      remote_mode_out <= 1'b0;
      local_mode_out <= 1'b0;
      local_led_out <= 1'b0;
      fwd_key_up_out <= 1'b0;
      fwd_key_down_out <= 1'b0;
    end
    else
    begin
      remote_mode_out <= !local_eff; // [RULE_12]
      local_mode_out <= local_eff; // [RULE_12]
      local_led_out <= mode_switch ? 1'b1 : (force_eff & blink); // [RULE_05]
      // keys go to the adjuster feeding the selected input
      fwd_key_up_out <= adj_sel && up_lvl; // [RULE_13]
      fwd_key_down_out <= adj_sel && down_lvl; // [RULE_13]
    end
  end

  // ========================================================================
  // AXI4-Lite slave: address and data captured in either order
  reg aw_held;
  reg w_held;
  reg [`LRS_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  // byte-lane merge of a write into a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (st[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  wire do_write = aw_held && w_held && !s_axi_bvalid_out;
  wire [31:0] ctrl_word = {28'h0, restart_mode_setting, mode_lock_setting};
  wire [31:0] link_word = {8'h0, force_local_link, local_source_link,
    remote_source_link};
  wire [31:0] m_ctrl = merge(ctrl_word, w_data, w_strb);
  wire [31:0] m_link = merge(link_word, w_data, w_strb);
  wire [31:0] m_slew = merge({16'h0, remote_slew_rate}, w_data, w_strb);
  wire [31:0] m_speed = merge({16'h0, key_ramp_speed}, w_data, w_strb);
  wire [31:0] m_low = merge({16'h0, register_lower_limit}, w_data, w_strb);
  wire [31:0] m_upp = merge({16'h0, register_upper_limit}, w_data, w_strb);
  wire signed [15:0] v_slew = m_slew[15:0];
  wire signed [15:0] v_speed = m_speed[15:0];
  wire signed [15:0] v_low = m_low[15:0];
  wire signed [15:0] v_upp = m_upp[15:0];

  // write side; out-of-range values are ignored, the old value stays
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {`LRS_ADDR_W{1'b0}};
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `LRS_RESP_OKAY;
      mode_lock_setting <= `LRS_RST_LOCK;
      restart_mode_setting <= `LRS_RST_RESTART;
      remote_source_link <= `LRS_RST_LINK;
      local_source_link <= `LRS_RST_LINK;
      force_local_link <= `LRS_RST_LINK;
      remote_slew_rate <= `LRS_RST_SLEW;
      key_ramp_speed <= `LRS_RST_SPEED;
      register_lower_limit <= `LRS_RST_LOW;
      register_upper_limit <= `LRS_RST_UPP;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= `LRS_RESP_OKAY;
        case ({aw_addr[`LRS_ADDR_W-1:2], 2'b00})
          `LRS_OFF_CTRL:
          begin
            if (m_ctrl[`LRS_CTRL_LOCK] <= `LRS_LOCK_LOCAL)
              mode_lock_setting <= m_ctrl[`LRS_CTRL_LOCK];
            if (m_ctrl[`LRS_CTRL_RESTART] <= `LRS_START_REMOTE)
              restart_mode_setting <= m_ctrl[`LRS_CTRL_RESTART];
          end
          `LRS_OFF_LINKS:
          begin
            if (link_ok(m_link[`LRS_LINK_REMOTE]))
              remote_source_link <= m_link[`LRS_LINK_REMOTE]; // [RULE_14]
            if (link_ok(m_link[`LRS_LINK_LOCAL]))
              local_source_link <= m_link[`LRS_LINK_LOCAL]; // [RULE_14]
            if (link_ok(m_link[`LRS_LINK_FORCE]))
              force_local_link <= m_link[`LRS_LINK_FORCE]; // [RULE_14]
          end
          `LRS_OFF_SLEW:
            if (v_slew >= `LRS_SLEW_MIN && v_slew <= `LRS_RATE_MAX)
              remote_slew_rate <= v_slew; // [RULE_08]
          `LRS_OFF_SPEED:
            if (v_speed >= 16'sh0000 && v_speed <= `LRS_RATE_MAX)
              key_ramp_speed <= v_speed; // [RULE_10]
          `LRS_OFF_LOW:
            if (v_low >= `LRS_LIM_MIN && v_low <= `LRS_LIM_MAX)
              register_lower_limit <= v_low; // [RULE_11]
          `LRS_OFF_UPP:
            if (v_upp >= `LRS_LIM_MIN && v_upp <= `LRS_LIM_MAX)
              register_upper_limit <= v_upp; // [RULE_11]
          `LRS_OFF_STATUS, `LRS_OFF_OUTPUT, `LRS_OFF_REGVAL:
            s_axi_bresp_out <= `LRS_RESP_OKAY;
          default:
            s_axi_bresp_out <= `LRS_RESP_SLVERR;
        endcase
      end
    end
  end

  // read side: one-cycle registered answer
  always @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= `LRS_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= `LRS_RESP_OKAY;
      case ({s_axi_araddr_in[`LRS_ADDR_W-1:2], 2'b00})
        `LRS_OFF_CTRL: s_axi_rdata_out <= ctrl_word;
        `LRS_OFF_LINKS: s_axi_rdata_out <= link_word;
        `LRS_OFF_SLEW: s_axi_rdata_out <= {16'h0, remote_slew_rate};
        `LRS_OFF_SPEED: s_axi_rdata_out <= {16'h0, key_ramp_speed};
        `LRS_OFF_LOW: s_axi_rdata_out <= {16'h0, register_lower_limit};
        `LRS_OFF_UPP: s_axi_rdata_out <= {16'h0, register_upper_limit};
        `LRS_OFF_STATUS: s_axi_rdata_out <= {26'h0, force_eff,
          local_led_out, remote_mode_out, local_mode_out, local_eff,
          mode_switch};
        `LRS_OFF_OUTPUT: s_axi_rdata_out <= {16'h0, setpoint_out};
        `LRS_OFF_REGVAL: s_axi_rdata_out <= {16'h0, local_reg};
        default:
        begin
          s_axi_rdata_out <= 32'h0;
          s_axi_rresp_out <= `LRS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

endmodule

// [test/lrs_far_side.sv]
// Purpose: far-side model of source blocks and panel keys
// Assumes: values change just after a rising edge
// Notes: a released key reads low, like a pulled-down pin
`timescale 1ns/1ps
module lrs_far_side
(
  input wire clock_in,
  output reg signed [15:0] remote_sp_out,
  output reg signed [15:0] local_sp_out,
  output reg force_out,
  output reg [2:0] keys_out
);
  // ======
  // idle: no key pressed, sources at zero
  initial
  begin
    remote_sp_out = 16'sh0000;
    local_sp_out = 16'sh0000;
    force_out = 1'b0;
    keys_out = 3'h0;
  end
  // key k (0 mode, 1 up, 2 down) held n cycles, slow or quick
  task press(input int k, input int n);
    @(posedge clock_in);
    keys_out[k] <= 1'b1;
    repeat (n) @(posedge clock_in);
    keys_out[k] <= 1'b0;
  endtask
  // new source values and force level
  task set_in(input logic signed [15:0] r,
    input logic signed [15:0] l, input logic f);
    @(posedge clock_in);
    remote_sp_out <= r;
    local_sp_out <= l;
    force_out <= f;
  endtask
endmodule

// [test/lrs_selector_assertions.sv]
// Purpose: port checks of the setpoint selector
// Assumes: one clock, synchronous active-low reset
// Notes: slew bound holds for every accepted rate, the default being the largest
`timescale 1ns/1ps
module lrs_selector_assertions
#(
  parameter SP_W = 16
)
(
  input wire clock_in,
  input wire nrst_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire signed [SP_W-1:0] setpoint_out,
  input wire remote_mode_out,
  input wire local_mode_out,
  input wire local_led_out
);
  // largest output step per tick at the default rate
  localparam int MAX_STEP = 2000;
  reg [1:0] rel_cnt;
  reg signed [SP_W-1:0] prev_sp;
  wire signed [SP_W:0] sp_step;
  default clocking dcb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  // ======
  // helpers: mode outputs lag reset release by two cycles
  assign sp_step = {setpoint_out[SP_W-1], setpoint_out}
    - {prev_sp[SP_W-1], prev_sp};
  always @(posedge clock_in)
  begin
    prev_sp <= setpoint_out;
    if (!nrst_in)
      rel_cnt <= 2'h0;
    else if (rel_cnt != 2'h3)
      rel_cnt <= rel_cnt + 2'h1;
  end
  // ======
  // bus handshakes
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out
      && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  property p_wr_answer;
    s_wr_taken |-> ##2 s_axi_bvalid_out;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("late write response");
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid_out;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("late read data");
  property p_bhold;
    s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_wr_refuse;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("write taken early");
  property p_rd_refuse;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("read taken early");
  // ======
  // mode, lamp and slew
  property p_mode_onehot;
    rel_cnt == 2'h3 |-> remote_mode_out != local_mode_out;
  endproperty
  a_mode_onehot: assert property (p_mode_onehot)
    else $error("mode outputs not exclusive");
  property p_led_remote;
    rel_cnt == 2'h3 && remote_mode_out |-> !local_led_out;
  endproperty
  a_led_remote: assert property (p_led_remote)
    else $error("lamp lit in remote");
  property p_slew;
    remote_mode_out && $past(remote_mode_out)
      |-> sp_step <= MAX_STEP && sp_step >= -MAX_STEP;
  endproperty
  a_slew: assert property (p_slew)
    else $error("remote output step too large");
endmodule
bind lrs_selector lrs_selector_assertions #(.SP_W(SP_W)) u_chk
(
  .clock_in(clock_in),
  .nrst_in(nrst_in),
  .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in),
  .setpoint_out(setpoint_out),
  .remote_mode_out(remote_mode_out),
  .local_mode_out(local_mode_out),
  .local_led_out(local_led_out)
);

// [test/lrs_selector_tb_top.sv]
// Purpose: self-checking bench of the setpoint selector
// Assumes: scan tick shortened to 20 clocks
// Notes: expected values follow from the settings written here
`timescale 1ns/1ps
`include "lrs_regs.vh"
module lrs_selector_tb_top;
  localparam int SCAN = 20;
  logic clock_in, nrst_in, awvalid, wvalid, bready, arvalid, rready, pl;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [7:0] disp;
  logic [1:0] r;
  logic signed [15:0] t;
  logic signed [15:0] tgt [3] = '{16'sh2710, -16'sh01F4, 16'sh0000};
  logic [31:0] rst_tbl [6] = '{32'h2, 32'h0, 32'h4E20, 32'h3E8, 32'h0,
    32'h2710};
  wire awready, wready, bvalid, arready, rvalid, frc, rmode, lmode, led;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire signed [15:0] rsp, lsp, sp;
  wire [2:0] keys;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  lrs_far_side far (.clock_in(clock_in), .remote_sp_out(rsp),
    .local_sp_out(lsp), .force_out(frc), .keys_out(keys));
  lrs_selector #(.SCAN_CYCLES(SCAN)) dut (.clock_in(clock_in),
    .nrst_in(nrst_in), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .remote_sp_in(rsp), .local_sp_in(lsp), .force_local_in(frc),
    .key_mode_in(keys[0]), .key_up_in(keys[1]), .key_down_in(keys[2]),
    .display_addr_in(disp), .retained_local_in(1'b1),
    .setpoint_out(sp), .remote_mode_out(rmode), .local_mode_out(lmode),
    .local_led_out(led), .fwd_key_up_out(), .fwd_key_down_out());
  // ======
  // clock and hang guard
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      end_of_test();
    end
  end
  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
    input logic signed [15:0] lo, input logic signed [15:0] hi);
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task ticks(input int k);
    repeat (k * SCAN) @(posedge clock_in);
  endtask
  // ready raised late so the slave must hold its answer
  task wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clock_in);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b1;
    @(posedge clock_in);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge clock_in);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b1;
    @(posedge clock_in);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ======
  // main sequence
  initial
  begin
    void'($urandom(32'h218C));
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, disp} = 52'h0;
    nrst_in = 1'b0;
    repeat (20) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    for (int i = 0; i < 6; i++)
    begin
      rd(6'(i * 4), d, r);
      chk("reset value", d, rst_tbl[i]);
    end
    rd(6'h24, d, r);
    chk("unmapped rdata", {d[29:0], r}, 32'h2);
    wr(6'h24, 32'h1, r);
    chk("unmapped bresp", r, 2'h2);
    ticks(2);
    chk("mode after reset", {rmode, lmode, led}, 3'h3);
    wr(`LRS_OFF_LOW, 32'h7FFF, r);
    rd(`LRS_OFF_LOW, d, r);
    chk("lower limit", d, 32'h0);
    wr(`LRS_OFF_CTRL, 32'h0, r);
    wr(`LRS_OFF_LINKS, 32'h00010000, r);
    far.press(0, 8);
    ticks(2);
    chk("remote by key", {rmode, lmode, led}, 3'h4);
    tgt[2] = 16'($urandom_range(9000, 1000));
    foreach (tgt[i])
    begin
      far.set_in(tgt[i], 16'sh0000, 1'b0);
      ticks(10);
      chk("remote output", sp, tgt[i]);
      rd(`LRS_OFF_REGVAL, d, r);
      chk("tracking", d, {16'h0, clamp(tgt[i], 16'sh0, 16'sh2710)});
    end
    t = tgt[2];
    far.set_in(t, 16'sh0000, 1'b1);
    ticks(2);
    chk("forced local", {rmode, lmode, sp}, {2'h1, t});
    n = 0;
    pl = led;
    repeat (27 * SCAN)
    begin
      @(posedge clock_in);
      n += 32'(led !== pl);
      pl = led;
    end
    chk("lamp toggles", 32'(n >= 4 && n <= 6), 32'h1);
    far.set_in(t, 16'sh0000, 1'b0);
    ticks(2);
    chk("force released", {rmode, lmode, led}, 3'h4);
    far.press(0, 8);
    wr(`LRS_OFF_LINKS, 32'h00010500, r);
    far.set_in(t, 16'sh1234, 1'b0);
    ticks(2);
    chk("local input", {lmode, led, sp}, {2'h3, 16'h1234});
    wr(`LRS_OFF_LINKS, 32'h00010000, r);
    wr(`LRS_OFF_UPP, 32'(t + 16'sh012C), r);
    far.press(1, 10 * SCAN);
    rd(`LRS_OFF_REGVAL, d, r);
    chk("ramp unshown", d, {16'h0, t});
    disp <= 8'hE1;
    far.press(1, 20 * SCAN);
    ticks(2);
    rd(`LRS_OFF_REGVAL, d, r);
    chk("ramp clamp", d,
      {16'h0, clamp(t + 16'sh0190, 16'sh0, t + 16'sh012C)});
    chk("local output", sp, t + 16'sh012C);
    for (int l = 1; l < 3; l++)
    begin
      wr(`LRS_OFF_CTRL, 32'(l), r);
      repeat (2)
      begin
        far.press(0, 8);
        ticks(1);
      end
      ticks(2);
      chk("locked mode", lmode, 32'(l == 2));
    end
    end_of_test();
  end
endmodule
